/* File: src/timebase_trigger_pkg.sv */
package timebase_trigger_pkg;
  localparam int unsigned INT_OSC_HZ = 20000000;
  localparam int unsigned BUS_LINES = 8;
  localparam int unsigned CLOCK_LINE = 7;
  localparam int unsigned STAR_LINE = 6;
  localparam int unsigned PFI_COUNT = 10;
  localparam int unsigned SRC_COUNT = PFI_COUNT + STAR_LINE + 1;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned DMA_CHANNELS = 3;
  localparam logic EDGE_RISING = 1'b0;
  localparam logic EDGE_FALLING = 1'b1;
  localparam logic DEST_SEQUENCER = 1'b0;
  localparam logic DEST_COUNTER = 1'b1;
endpackage

/* File: src/timebase_trigger_select.sv */
`timescale 1ns/1ps
`default_nettype none
module timebase_trigger_select #(
  parameter bit HAS_TRIGGER_BUS = 1'b1,
  parameter int unsigned DMA_CHANNELS = timebase_trigger_pkg::DMA_CHANNELS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic timebase_from_bus_in,
  input wire logic drive_bus_clock_in,
  input wire logic backplane_present_in,
  input wire logic [timebase_trigger_pkg::PFI_COUNT-1:0] programmable_function_pin_in,
  input wire logic [timebase_trigger_pkg::BUS_LINES-1:0] system_trigger_bus_in,
  input wire logic [timebase_trigger_pkg::SRC_W-1:0] trig_source_in,
  input wire logic trig_edge_in,
  input wire logic trig_dest_in,
  input wire logic trig_enable_in,
  input wire logic dma_request_in,
  input wire logic dma_release_in,
  input wire logic irq_mode_in,
  input wire logic transfer_ready_in,
  output logic use_bus_timebase_out,
  output logic [timebase_trigger_pkg::BUS_LINES-1:0] system_trigger_bus_out,
  output logic [timebase_trigger_pkg::BUS_LINES-1:0] system_trigger_bus_oe_out,
  output logic seq_trigger_out,
  output logic counter_trigger_out,
  output logic dma_grant_out,
  output logic dma_error_out,
  output logic [DMA_CHANNELS:0] dma_in_use_out,
  output logic irq_out
);
  localparam int unsigned CW = $clog2(DMA_CHANNELS + 1);
  localparam int unsigned UW = DMA_CHANNELS + 1;

  // bus usable only on a bus-equipped variant in a backplane chassis
  logic bus_ok;
  assign bus_ok = HAS_TRIGGER_BUS && backplane_present_in;

  // selects one trigger source: pins first, then bus lines 0..6
  function automatic logic pick_source(
    input logic [timebase_trigger_pkg::SRC_W-1:0] sel,
    input logic [timebase_trigger_pkg::PFI_COUNT-1:0] pins,
    input logic [timebase_trigger_pkg::BUS_LINES-1:0] bus,
    input logic bus_en
  );
    logic r;
    r = 1'b0;
    for (int i = 0; i < timebase_trigger_pkg::SRC_COUNT; i++)
    begin
      if (sel == (timebase_trigger_pkg::SRC_W)'(i))
      begin
        if (i < timebase_trigger_pkg::PFI_COUNT)
          r = pins[i];
        else
          r = bus[i - timebase_trigger_pkg::PFI_COUNT] & bus_en;
      end
    end
    return r;
  endfunction

  // next channel count for a request and a release landing in one cycle
  // a refused request leaves the count alone; a paired release frees the slot it reuses
  function automatic logic [CW-1:0] next_used(
    input logic req,
    input logic rel_ok,
    input logic [CW-1:0] used
  );
    logic [CW-1:0] n;
    n = used;
    if (req && (used < CW'(DMA_CHANNELS) || rel_ok))
    begin
      if (!rel_ok)
        n = used + CW'(1);
    end
    else if (rel_ok)
      n = used - CW'(1);
    return n;
  endfunction

  localparam int unsigned BUS_LINES_W = timebase_trigger_pkg::BUS_LINES;

  // timebase and bus driver state
  logic tb_q, tb_d;
  logic [BUS_LINES_W-1:0] out_q, out_d, oe_q, oe_d;
  // trigger synchroniser, edge history and pulses
  logic sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
  logic seq_q, seq_d, cnt_q, cnt_d, fire;
  // dma allocation state
  logic [CW-1:0] used_q, used_d;
  logic grant_q, grant_d, err_q, err_d, rel_ok;
  // interrupt request state
  logic irq_q, irq_d;

  // timebase select and export; export only on line 7, only off the internal oscillator
  // lines 0..6 are never enabled, so another board may own them freely
  always_comb
  begin
    tb_d = timebase_from_bus_in & bus_ok;
    out_d = '0;
    oe_d = '0;
    if (bus_ok && !timebase_from_bus_in && drive_bus_clock_in)
    begin
      out_d[timebase_trigger_pkg::CLOCK_LINE] = 1'b1;
      oe_d[timebase_trigger_pkg::CLOCK_LINE] = 1'b1;
    end
    oe_d[timebase_trigger_pkg::STAR_LINE] = 1'b0;
  end

  // timebase registers; reset picks internal oscillator, driver off
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tb_q <= 1'b0;
      out_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      tb_q <= tb_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // trigger path: select, two sync stages, edge compare, route
  // only the second stage feeds the edge logic, so a metastable first stage never fires
  always_comb
  begin
    sync1_d = pick_source(trig_source_in, programmable_function_pin_in,
                          system_trigger_bus_in, bus_ok);
    sync2_d = sync1_q;
    prev_d = sync2_q;
    if (trig_edge_in == timebase_trigger_pkg::EDGE_RISING)
      fire = sync2_q & ~prev_q;
    else
      fire = ~sync2_q & prev_q;
    fire = fire & trig_enable_in;
    seq_d = fire && (trig_dest_in == timebase_trigger_pkg::DEST_SEQUENCER);
    cnt_d = fire && (trig_dest_in == timebase_trigger_pkg::DEST_COUNTER);
  end

  // trigger registers; history resets low, so a source idling high
  // after reset reads as one rising edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      seq_q <= 1'b0;
      cnt_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      seq_q <= seq_d;
      cnt_q <= cnt_d;
    end
  end

  // dma channel pool: grant while free or with a paired release, otherwise refuse with error when full
  // a release with nothing held is ignored, so the count never wraps
  always_comb
  begin
    rel_ok = dma_release_in && (used_q != '0);
    grant_d = 1'b0;
    err_d = 1'b0;
    if (dma_request_in)
    begin
      if (used_q < CW'(DMA_CHANNELS) || rel_ok)
        grant_d = 1'b1;
      else
        err_d = 1'b1;
    end
    used_d = next_used(dma_request_in, rel_ok, used_q);
  end

  // dma registers; pool starts empty
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      used_q <= '0;
      grant_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      used_q <= used_d;
      grant_q <= grant_d;
      err_q <= err_d;
    end
  end

  // interrupt request follows readiness only in interrupt transfer mode
  always_comb
  begin
    irq_d = irq_mode_in & transfer_ready_in;
  end

  // interrupt register; quiet in reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  // outputs straight from the registers

  assign use_bus_timebase_out = tb_q;
  assign system_trigger_bus_out = out_q;
  assign system_trigger_bus_oe_out = oe_q;
  assign seq_trigger_out = seq_q;
  assign counter_trigger_out = cnt_q;
  assign dma_grant_out = grant_q;
  assign dma_error_out = err_q;
  assign dma_in_use_out = UW'(used_q);
  assign irq_out = irq_q;
endmodule
`default_nettype wire

/* File: sim/timebase_trigger_select_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module timebase_trigger_select_asserts #(parameter int unsigned DMA_CHANNELS = 3) (
  input wire logic clk_in, rst_in, timebase_from_bus_in, drive_bus_clock_in, trig_edge_in,
  input wire logic backplane_present_in, trig_dest_in, trig_enable_in, irq_mode_in,
  input wire logic dma_request_in, dma_release_in, transfer_ready_in, use_bus_timebase_out,
  input wire logic [9:0] programmable_function_pin_in,
  input wire logic [4:0] trig_source_in,
  input wire logic [7:0] system_trigger_bus_oe_out,
  input wire logic [DMA_CHANNELS:0] dma_in_use_out,
  input wire logic seq_trigger_out, dma_grant_out, dma_error_out, irq_out
);
  // every check runs on the block clock, quiet in reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_STAR_IN: assert property (!system_trigger_bus_oe_out[6])
    else $error("star line driven");
  AST_CLK_ONLY: assert property (system_trigger_bus_oe_out[5:0] == 6'h00)
    else $error("trigger line driven");
  AST_TB_SEL: assert property (use_bus_timebase_out == $past(timebase_from_bus_in && backplane_present_in))
    else $error("timebase select wrong");
  AST_EXPORT: assert property ($rose(system_trigger_bus_oe_out[7]) |-> $past(drive_bus_clock_in && !timebase_from_bus_in))
    else $error("export without cause");
  AST_NO_PLANE: assert property (!backplane_present_in |=> !use_bus_timebase_out && !system_trigger_bus_oe_out[7])
    else $error("bus used without backplane");
  AST_TRIG_RISE: assert property ($rose(programmable_function_pin_in[0]) && trig_source_in == 5'h00 && !trig_edge_in && !trig_dest_in && trig_enable_in |-> ##3 seq_trigger_out)
    else $error("rising trigger missed");
  AST_DMA_FULL: assert property (dma_request_in && !dma_release_in && dma_in_use_out == DMA_CHANNELS |=> dma_error_out && !dma_grant_out)
    else $error("full request not refused");
  AST_IRQ: assert property (irq_out == $past(irq_mode_in && transfer_ready_in))
    else $error("irq wrong");
endmodule
bind timebase_trigger_select timebase_trigger_select_asserts #(.DMA_CHANNELS(DMA_CHANNELS)) chk_u (.*);
`default_nettype wire

/* File: sim/trigger_bus_boards.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_bus_boards (
  input wire logic [7:0] system_trigger_bus_oe_out,
  input wire logic [7:0] system_trigger_bus_out,
  input wire logic [7:0] other_drive,
  output logic [7:0] system_trigger_bus_in
);
  // master board levels on lines the device leaves free
  // the master only toggles its shared trigger once this slave is set up
  assign system_trigger_bus_in = (system_trigger_bus_oe_out & system_trigger_bus_out)
    | (~system_trigger_bus_oe_out & other_drive);
endmodule
`default_nettype wire

/* File: sim/timebase_trigger_select_test.sv */
`timescale 1ns/1ps
`default_nettype none
module timebase_trigger_select_test;
  logic clk_in = 1'h0, rst_in = 1'h1, timebase_from_bus_in = 1'h0, drive_bus_clock_in = 1'h0;
  logic backplane_present_in = 1'h1, trig_edge_in = 1'h0, trig_dest_in = 1'h0, irq_out;
  logic trig_enable_in = 1'h1, dma_request_in = 1'h0, dma_release_in = 1'h0, dma_grant_out;
  logic irq_mode_in = 1'h0, transfer_ready_in = 1'h0, use_bus_timebase_out, seq_trigger_out;
  logic counter_trigger_out, dma_error_out;
  logic [16:0] level = 17'h00000;
  logic [7:0] system_trigger_bus_in, system_trigger_bus_out, system_trigger_bus_oe_out;
  logic [4:0] trig_source_in = 5'h00;
  logic [3:0] dma_in_use_out;
  int fail_count = 0, total_checks = 0, srcs[4] = '{0, 9, 10, 16};
  wire logic [9:0] programmable_function_pin_in = level[9:0];
  wire logic [7:0] other_drive = {1'h0, level[16:10]};
  always #50 clk_in = ~clk_in;
  timebase_trigger_select dut_u (.*);
  trigger_bus_boards boards_u (.*);
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one edge on source s, then the opposite edge: one pulse when enabled, none when disabled
  task automatic trig(input int s, input logic e, input logic d, input logic en);
    int ns = 0, nc = 0;
    {trig_source_in, trig_edge_in, trig_dest_in, trig_enable_in, level[s]} = {5'(s), e, d, en, e};
    repeat (5) @(negedge clk_in);
    for (int i = 0; i < 16; i++)
    begin
      level[s] = (i < 8) ? ~e : e;
      @(negedge clk_in);
      ns += seq_trigger_out;
      nc += counter_trigger_out;
    end
    check(16'(ns), 16'(en && d == 1'h0));
    check(16'(nc), 16'(en && d == 1'h1));
  endtask
  // reset, timebase table, triggers, then dma exhaustion
  initial
  begin
    repeat (5) @(negedge clk_in);
    rst_in = 1'h0;
    check({use_bus_timebase_out, system_trigger_bus_oe_out, dma_in_use_out, irq_out}, 16'h0);
    for (int i = 0; i < 32; i++)
    begin
      {transfer_ready_in, irq_mode_in, backplane_present_in, timebase_from_bus_in, drive_bus_clock_in} = 5'(i);
      @(negedge clk_in);
      check(use_bus_timebase_out, i[2] & i[1]);
      check(system_trigger_bus_oe_out, {i[2] & i[0] & ~i[1], 7'h00});
      check(system_trigger_bus_out, {i[2] & i[0] & ~i[1], 7'h00});
      check(irq_out, i[4] & i[3]);
    end
    foreach (srcs[k])
      for (int m = 0; m < 8; m++)
        trig(srcs[k], m[0], m[1], !m[2]);
    dma_request_in = 1'h1;
    for (int i = 1; i <= 4; i++)
    begin
      @(negedge clk_in);
      check({dma_grant_out, dma_error_out, dma_in_use_out}, {i < 4, i == 4, 4'(i < 4 ? i : 3)});
    end
    {dma_request_in, dma_release_in} = 2'h1;
    @(negedge clk_in);
    dma_request_in = 1'h1;
    @(negedge clk_in);
    check({dma_grant_out, dma_error_out, dma_in_use_out}, 16'h22);
    results;
  end
  // hang guard well past the expected run
  initial
  begin
    #200000;
    fail_count++;
    results;
  end
endmodule
`default_nettype wire
